// ==== sasb_pkg.sv ====
// Constants and types for the power-down and subtract-with-borrow execution block
// Summary of operation
// (RL1) Opcode 0003h enters power-down, stops oscillator
// (RL2) Power-down instruction clears low-power-entry flag
// (RL3) Power-down instruction sets watchdog-expiry flag
// (RL4) Power-down clears watchdog counter and its postscaler
// (RL5) Watchdog wake-up clears the watchdog-expiry flag
// (RL6) Power-down: one word, one cycle, sleeps in Q4
// (RL7) Subtract: acc minus file minus borrow, flags
// (RL8) Destination bit picks accumulator or file register
// (RL9) Bank bit picks access bank or pointer bank
// (RL10) Indexed literal offset when extended and f<=5Fh; the code also requires the bank bit clear
// (RL11) Subtract: read Q2, compute Q3, write Q4
`default_nettype none
package sasb_pkg;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  localparam logic [15:0] OPC_POWER_DOWN  = 16'h0003;
  localparam logic [5:0]  OPC_SUB_BORROW  = 6'h15;   // Upper six opcode bits 0101 01
  localparam int          OPC_HI_POS      = 10;
  localparam int          DEST_BIT_POS    = 9;
  localparam int          BANK_BIT_POS    = 8;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
  localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_SFR_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic        EXPIRY_RESET    = 1'h1;
  localparam logic        LOW_POWER_RESET = 1'h1;
  localparam logic        FLAG_RESET      = 1'h0;

  // Instruction cycle phases
  typedef enum logic [1:0] {SASB_Q1, SASB_Q2, SASB_Q3, SASB_Q4} sasb_phase_t;

endpackage
`default_nettype wire

// ==== sasb_alu_if.sv ====
// Operand and result bundle between the execution core and the subtractor
`timescale 1ns/100ps
`default_nettype none
interface sasb_alu_if;
  logic [7:0] acc;
  logic [7:0] operand;
  logic       carry_in;
  logic [7:0] result;
  logic       negative;
  logic       signed_range;
  logic       zero;
  logic       half_carry;
  logic       carry_out;

  modport core (output acc, operand, carry_in,
                input  result, negative, signed_range, zero, half_carry, carry_out);
  modport alu  (input  acc, operand, carry_in,
                output result, negative, signed_range, zero, half_carry, carry_out);
endinterface
`default_nettype wire

// ==== sasb_sub_alu.sv ====
// Eight-bit subtract-with-borrow datapath and its flag logic
`timescale 1ns/100ps
`default_nettype none
module sasb_sub_alu
(
  sasb_alu_if.alu bus
);

  // ----------------------------------------------------------------
  // Two's complement: acc + ~operand + carry, carry means no borrow
  // ----------------------------------------------------------------
  wire logic [8:0] full_sum;
  wire logic [4:0] low_sum;
  wire logic [7:0] inv_operand;

  assign inv_operand = ~bus.operand;
  assign full_sum    = {1'b0, bus.acc} + {1'b0, inv_operand} + {8'h00, bus.carry_in}; // [RL7]
  assign low_sum     = {1'b0, bus.acc[3:0]} + {1'b0, inv_operand[3:0]}
                       + {4'h0, bus.carry_in};

  // Flags follow the sum; overflow when operand signs differ and sign flips
  assign bus.result       = full_sum[7:0];
  assign bus.carry_out    = full_sum[8];                                    // [RL7]
  assign bus.half_carry   = low_sum[4];                                     // [RL7]
  assign bus.negative     = full_sum[7];                                    // [RL7]
  assign bus.zero         = (full_sum[7:0] == 8'h00);                       // [RL7]
  assign bus.signed_range = (bus.acc[7] != bus.operand[7])
                            && (full_sum[7] != bus.acc[7]);                 // [RL7]

endmodule
`default_nettype wire

// ==== sasb_exec.sv ====
// Execution of the power-down and subtract-file-from-accumulator-with-borrow instructions
`timescale 1ns/100ps
`default_nettype none
module sasb_exec
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] instr_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic [3:0]  data_bank_pointer_in,
  input  wire logic        ext_set_enable_in,
  input  wire logic [11:0] index_base_in,
  input  wire logic        acc_load_in,
  input  wire logic [7:0]  acc_load_data_in,
  input  wire logic        carry_load_data_in,
  input  wire logic        wake_event_in,
  input  wire logic        watchdog_wake_in,
  output logic [1:0]       phase_out,
  output logic [11:0]      mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic [7:0]       mem_wdata_out,
  output logic [7:0]       acc_out,
  output logic             carry_flag_out,
  output logic             half_carry_flag_out,
  output logic             zero_flag_out,
  output logic             signed_range_flag_out,
  output logic             negative_flag_out,
  output logic             watchdog_expiry_flag_out,
  output logic             low_power_entry_flag_out,
  output logic             watchdog_clear_out,
  output logic             osc_run_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sasb_pkg::sasb_phase_t phase_reg;
  sasb_pkg::sasb_phase_t phase_next;
  logic [15:0] instr_reg;
  logic [7:0]  operand_reg;
  logic [7:0]  result_reg;
  logic [7:0]  acc_reg;
  logic        c_reg;
  logic        dc_reg;
  logic        z_reg;
  logic        ov_reg;
  logic        n_reg;
  logic        expiry_reg;
  logic        low_power_reg;
  logic        run_reg;
  logic        wd_clear_reg;
  logic [11:0] addr_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic [7:0]  wdata_reg;
  logic [1:0]  wake_meta_reg;
  logic [1:0]  wake_sync_reg;

  sasb_alu_if alu_bus ();

  sasb_sub_alu sasb_sub_alu_inst
  (
    .bus (alu_bus)
  );

  // ----------------------------------------------------------------
  // Wake sources arrive from outside the core clock domain
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wake_meta_reg <= 2'h0;
      wake_sync_reg <= 2'h0;
    end
    else
    begin
      wake_meta_reg <= {watchdog_wake_in, wake_event_in};
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Decode of the live opcode in Q1 and of the held opcode later
  // ----------------------------------------------------------------
  wire logic       in_q1;
  wire logic       in_q2;
  wire logic       in_q3;
  wire logic       in_q4;
  wire logic       dec_sub_now;
  wire logic       held_sub;
  wire logic       held_sleep;
  wire logic       held_dest_file;
  wire logic       any_wake;
  wire logic       wd_wake;

  assign in_q1          = (phase_reg == sasb_pkg::SASB_Q1);
  assign in_q2          = (phase_reg == sasb_pkg::SASB_Q2);
  assign in_q3          = (phase_reg == sasb_pkg::SASB_Q3);
  assign in_q4          = (phase_reg == sasb_pkg::SASB_Q4);
  assign dec_sub_now    = (instr_in[15:sasb_pkg::OPC_HI_POS] == sasb_pkg::OPC_SUB_BORROW);
  assign held_sub       = (instr_reg[15:sasb_pkg::OPC_HI_POS] == sasb_pkg::OPC_SUB_BORROW);
  assign held_sleep     = (instr_reg == sasb_pkg::OPC_POWER_DOWN);                // [RL1]
  assign held_dest_file = instr_reg[sasb_pkg::DEST_BIT_POS];                      // [RL8]
  assign any_wake       = wake_sync_reg[0] | wake_sync_reg[1];
  assign wd_wake        = wake_sync_reg[1];

  // ----------------------------------------------------------------
  // File address: indexed, access bank or pointer-selected bank
  // ----------------------------------------------------------------
  wire logic [7:0]  file_field;
  wire logic        bank_sel;
  wire logic        indexed_mode;
  wire logic [11:0] access_addr;
  wire logic [11:0] banked_addr;
  wire logic [11:0] indexed_addr;
  wire logic [11:0] file_addr;

  assign file_field   = instr_in[7:0];
  assign bank_sel     = instr_in[sasb_pkg::BANK_BIT_POS];
  assign indexed_mode = !bank_sel && ext_set_enable_in
                        && (file_field <= sasb_pkg::INDEXED_LIMIT);               // [RL10]
  // Low part of the access bank maps to bank 0, the rest to the special bank
  assign access_addr  = (file_field <= sasb_pkg::INDEXED_LIMIT)
                        ? {sasb_pkg::ACCESS_LOW_BANK, file_field}
                        : {sasb_pkg::ACCESS_SFR_BANK, file_field};                // [RL9]
  assign banked_addr  = {data_bank_pointer_in, file_field};                       // [RL9]
  assign indexed_addr = index_base_in + {4'h0, file_field};                       // [RL10]
  assign file_addr    = indexed_mode ? indexed_addr
                        : (bank_sel ? banked_addr : access_addr);                 // [RL9]

  // ----------------------------------------------------------------
  // Subtractor hookup: operand captured in Q2, borrow is current carry
  // ----------------------------------------------------------------
  assign alu_bus.acc      = acc_reg;
  assign alu_bus.operand  = operand_reg;
  assign alu_bus.carry_in = c_reg;                                                // [RL7]

  // ----------------------------------------------------------------
  // Phase sequencer; holds in Q1 while the oscillator is stopped
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (phase_reg)
      sasb_pkg::SASB_Q1: phase_next = run_reg ? sasb_pkg::SASB_Q2 : sasb_pkg::SASB_Q1;
      sasb_pkg::SASB_Q2: phase_next = sasb_pkg::SASB_Q3;
      sasb_pkg::SASB_Q3: phase_next = sasb_pkg::SASB_Q4;
      sasb_pkg::SASB_Q4: phase_next = sasb_pkg::SASB_Q1;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      phase_reg <= sasb_pkg::SASB_Q1;
    else
      phase_reg <= phase_next;                                                    // [RL6] [RL11]
  end

  // ----------------------------------------------------------------
  // Q1: latch opcode; no fetch is taken while asleep
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      instr_reg <= 16'h0000;
    else if (in_q1 && run_reg)
      instr_reg <= instr_in;
  end

  // ----------------------------------------------------------------
  // File read in Q2, operand captured at the end of Q2
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      addr_reg    <= 12'h000;
      rd_reg      <= 1'b0;
      operand_reg <= 8'h00;
    end
    else
    begin
      rd_reg <= in_q1 && run_reg && dec_sub_now;                                  // [RL11]
      if (in_q1 && run_reg && dec_sub_now)
        addr_reg <= file_addr;                                                    // [RL9] [RL10]
      if (in_q2 && held_sub)
        operand_reg <= mem_rdata_in;                                              // [RL11]
    end
  end

  // ----------------------------------------------------------------
  // Q3: compute and update arithmetic flags; queue file write for Q4
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      result_reg <= 8'h00;
      dc_reg     <= sasb_pkg::FLAG_RESET;
      z_reg      <= sasb_pkg::FLAG_RESET;
      ov_reg     <= sasb_pkg::FLAG_RESET;
      n_reg      <= sasb_pkg::FLAG_RESET;
      wr_reg     <= 1'b0;
      wdata_reg  <= 8'h00;
    end
    else
    begin
      wr_reg <= in_q3 && held_sub && held_dest_file;                              // [RL8] [RL11]
      if (in_q3 && held_sub)
      begin
        result_reg <= alu_bus.result;                                             // [RL7]
        wdata_reg  <= alu_bus.result;
        dc_reg     <= alu_bus.half_carry;
        z_reg      <= alu_bus.zero;
        ov_reg     <= alu_bus.signed_range;
        n_reg      <= alu_bus.negative;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and carry; instruction results win over a side load
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acc_reg <= sasb_pkg::ACC_RESET;
      c_reg   <= sasb_pkg::FLAG_RESET;
    end
    else
    begin
      if (in_q4 && held_sub && !held_dest_file)
        acc_reg <= result_reg;                                                    // [RL8] [RL11]
      else if (acc_load_in)
        acc_reg <= acc_load_data_in;
      // Carry changes in Q3 so a same-cycle side load cannot race the result
      if (in_q3 && held_sub)
        c_reg <= alu_bus.carry_out;                                               // [RL7]
      else if (acc_load_in)
        c_reg <= carry_load_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Power-down: flags and watchdog clear in Q3, sleep entered in Q4
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      expiry_reg    <= sasb_pkg::EXPIRY_RESET;
      low_power_reg <= sasb_pkg::LOW_POWER_RESET;
      wd_clear_reg  <= 1'b0;
      run_reg       <= 1'b1;
    end
    else
    begin
      wd_clear_reg <= in_q3 && held_sleep;                                        // [RL4] [RL6]
      if (in_q3 && held_sleep)
      begin
        expiry_reg    <= 1'b1;                                                    // [RL3]
        low_power_reg <= 1'b0;                                                    // [RL2]
      end
      else if (!run_reg && wd_wake)
        expiry_reg <= 1'b0;                                                       // [RL5]
      // Wake sources are only looked at while asleep; an early wake is dropped
      if (in_q4 && held_sleep)
        run_reg <= 1'b0;                                                          // [RL1] [RL6]
      else if (!run_reg && any_wake)
        run_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each taken from a flip-flop
  // ----------------------------------------------------------------
  assign phase_out                = phase_reg;
  assign mem_addr_out             = addr_reg;
  assign mem_rd_out               = rd_reg;
  assign mem_wr_out               = wr_reg;
  assign mem_wdata_out            = wdata_reg;
  assign acc_out                  = acc_reg;
  assign carry_flag_out           = c_reg;
  assign half_carry_flag_out      = dc_reg;
  assign zero_flag_out            = z_reg;
  assign signed_range_flag_out    = ov_reg;
  assign negative_flag_out        = n_reg;
  assign watchdog_expiry_flag_out = expiry_reg;
  assign low_power_entry_flag_out = low_power_reg;
  assign watchdog_clear_out       = wd_clear_reg;
  assign osc_run_out              = run_reg;                                      // [RL1]

endmodule
`default_nettype wire

// ==== sasb_exec_assertions.sv ====
// Concurrent checks on the ports of the execution block
`timescale 1ns/100ps
`default_nettype none
module sasb_exec_assertions
(
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       acc_load_in,
  input wire logic [1:0] phase_out,
  input wire logic       mem_rd_out,
  input wire logic       mem_wr_out,
  input wire logic [7:0] acc_out,
  input wire logic       zero_flag_out,
  input wire logic       watchdog_expiry_flag_out,
  input wire logic       low_power_entry_flag_out,
  input wire logic       watchdog_clear_out,
  input wire logic       osc_run_out
);
  // ----------------------------------------------------------------
  // Timing of phases, file access and sleep
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // Phase wraps in two bits, so Q4 steps back to Q1
  chk_phase_step: assert property (
    osc_run_out |=> phase_out == $past(phase_out) + 2'h1) else $error("Phase did not advance");
  chk_read_q2: assert property (
    mem_rd_out |-> phase_out == 2'h1 ##1 !mem_rd_out) else $error("File read outside Q2");
  chk_write_q4: assert property (
    mem_wr_out |-> phase_out == 2'h3 && $past(mem_rd_out, 2)) else $error("File write misplaced");
  chk_sleep_entry: assert property (
    $fell(osc_run_out) |-> $past(watchdog_clear_out) && !low_power_entry_flag_out
    && watchdog_expiry_flag_out) else $error("Sleep entered without flag updates");
  chk_clear_pulse: assert property (
    watchdog_clear_out |-> phase_out == 2'h3 ##1 !osc_run_out) else $error("Bad counter clear");
  chk_asleep_quiet: assert property (
    !osc_run_out |-> !mem_rd_out && !mem_wr_out && phase_out == 2'h0)
    else $error("Activity while asleep");
  // Accumulator moves only after Q4 or after a side load
  chk_acc_moment: assert property (
    $changed(acc_out) |-> phase_out == 2'h0 || $past(acc_load_in))
    else $error("Accumulator changed at wrong time");
  chk_flag_moment: assert property (
    $changed(zero_flag_out) |-> phase_out == 2'h3) else $error("Zero flag changed outside Q3");
  chk_wake_expiry: assert property (
    $fell(watchdog_expiry_flag_out) |-> $rose(osc_run_out)) else $error("Expiry cleared awake");
  chk_low_power: assert property (
    !$rose(low_power_entry_flag_out)) else $error("Low-power flag set without reset");
endmodule

bind sasb_exec sasb_exec_assertions sasb_exec_assertions_inst
(
  .core_clk_in, .rst_in, .acc_load_in, .phase_out, .mem_rd_out, .mem_wr_out, .acc_out,
  .zero_flag_out, .watchdog_expiry_flag_out, .low_power_entry_flag_out,
  .watchdog_clear_out, .osc_run_out
);
`default_nettype wire

// ==== sasb_exec_tb_top.sv ====
// Self-checking testbench for the power-down and subtract-with-borrow block
`timescale 1ns/100ps
`default_nettype none
module sasb_exec_tb_top;
  typedef struct packed {logic [11:0] addr; logic d; logic [12:0] res;} sasb_note_t;
  logic        core_clk_in, rst_in, ext_set_enable_in, acc_load_in, carry_load_data_in;
  logic        wake_event_in, watchdog_wake_in, c_model;
  logic [15:0] instr_in;
  logic [7:0]  mem_rdata_in, acc_load_data_in, w_model;
  logic [3:0]  data_bank_pointer_in;
  logic [11:0] index_base_in;
  logic [31:0] seed;
  wire  [1:0]  phase_out;
  wire  [11:0] mem_addr_out;
  wire  [7:0]  mem_wdata_out, acc_out;
  wire         mem_rd_out, mem_wr_out, carry_flag_out, half_carry_flag_out, zero_flag_out;
  wire         signed_range_flag_out, negative_flag_out, watchdog_expiry_flag_out;
  wire         low_power_entry_flag_out, watchdog_clear_out, osc_run_out;
  int          err_count, tests_run;
  sasb_note_t  notes[$];

  sasb_exec sasb_exec_inst
  (
    .core_clk_in, .rst_in, .instr_in, .mem_rdata_in, .data_bank_pointer_in,
    .ext_set_enable_in, .index_base_in, .acc_load_in, .acc_load_data_in,
    .carry_load_data_in, .wake_event_in, .watchdog_wake_in, .phase_out, .mem_addr_out,
    .mem_rd_out, .mem_wr_out, .mem_wdata_out, .acc_out, .carry_flag_out,
    .half_carry_flag_out, .zero_flag_out, .signed_range_flag_out, .negative_flag_out,
    .watchdog_expiry_flag_out, .low_power_entry_flag_out, .watchdog_clear_out, .osc_run_out
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #12.5 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Packs {N, OV, Z, DC, C, result}; a set carry means no borrow
  function automatic logic [12:0] sub_expect(input logic [7:0] w, input logic [7:0] f,
                                             input logic c);
    logic [8:0] s;
    logic [4:0] l;
    // Plain subtraction; bit 8 or bit 4 set means a borrow was needed
    s = {1'b0, w} - {1'b0, f} - {8'h00, !c};
    l = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, !c};
    return {s[7], (w[7] != f[7]) && (s[7] != w[7]), s[7:0] == 8'h00, !l[4], !s[8], s[7:0]};
  endfunction

  task automatic cyc();
    @(negedge core_clk_in);
  endtask

  task automatic check(input string nm, input logic [12:0] e, input logic [12:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded wait for the next Q1 of a running core
  task automatic wait_q1();
    for (int n = 0; n < 12; n++)
    begin
      cyc();
      if (phase_out === 2'h0 && osc_run_out === 1'b1)
        return;
    end
    check("wait for Q1", 13'h0001, 13'h0000);
    end_of_test();
  endtask

  // Drives one subtract in Q1 and notes what must come out
  task automatic sub_op(input logic d, input logic a, input logic x, input logic [7:0] f);
    logic [11:0] ad;
    sasb_note_t  n;
    seed = lfsr_next(seed);
    mem_rdata_in = seed[15:8];
    data_bank_pointer_in = seed[19:16];
    index_base_in = seed[31:20];
    ext_set_enable_in = x;
    ad = a ? {seed[19:16], f} : (x && f <= 8'h5f) ? seed[31:20] + {4'h0, f}
       : {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
    n = '{ad, d, sub_expect(w_model, seed[15:8], c_model)};
    notes.push_back(n);
    instr_in = {sasb_pkg::OPC_SUB_BORROW, d, a, f};
    repeat (3) cyc();
    c_model = n.res[8];
    if (!d)
      w_model = n.res[7:0];
  endtask

  // ----------------------------------------------------------------
  // Output watcher: any file read takes the oldest note
  // ----------------------------------------------------------------
  initial
  begin : watcher
    sasb_note_t n;
    forever
    begin
      cyc();
      if (mem_rd_out === 1'b1)
      begin
        if (notes.size() == 0)
          check("unexpected mem_rd_out", 13'h0000, 13'h0001);
        else
        begin
          n = notes.pop_front();
          check("mem_addr_out", {1'b0, n.addr}, {1'b0, mem_addr_out});
          repeat (2) cyc();
          check("flags", {8'h00, n.res[12:8]}, {8'h00, negative_flag_out,
                signed_range_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out});
          check("mem_wr_out", {12'h000, n.d}, {12'h000, mem_wr_out});
          if (n.d)
            check("mem_wdata_out", {5'h00, n.res[7:0]}, {5'h00, mem_wdata_out});
          cyc();
          if (!n.d)
            check("acc_out", {5'h00, n.res[7:0]}, {5'h00, acc_out});
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    instr_in = 16'h0000;
    mem_rdata_in = 8'h00;
    data_bank_pointer_in = 4'h0;
    ext_set_enable_in = 1'b0;
    index_base_in = 12'h000;
    acc_load_in = 1'b0;
    acc_load_data_in = 8'h00;
    carry_load_data_in = 1'b0;
    wake_event_in = 1'b0;
    watchdog_wake_in = 1'b0;
    seed = 32'h508d;
    w_model = 8'h00;
    c_model = 1'b0;
    repeat (3) cyc();
    check("reset state", 13'h0007, {phase_out, acc_out, watchdog_expiry_flag_out,
          low_power_entry_flag_out, osc_run_out});
    rst_in = 1'b0;
    // Every d, a and extended-set mix against the 5Fh boundary and random f
    for (int i = 0; i < 48; i++)
    begin
      wait_q1();
      if (seed[3])
      begin
        acc_load_in = 1'b1;
        acc_load_data_in = seed[31:24];
        carry_load_data_in = seed[5];
        instr_in = seed[0] ? 16'h5c00 : 16'h0002; // Near-miss opcodes must do nothing
        w_model = seed[31:24];
        c_model = seed[5];
        cyc();
        acc_load_in = 1'b0;
        wait_q1();
      end
      sub_op(i[0], i[1], i[2], (i[4:3] == 2'h0) ? 8'h5f : (i[4:3] == 2'h1) ? 8'h60 : seed[7:0]);
    end
    // First sleep wakes by watchdog, second by another source
    for (int k = 0; k < 2; k++)
    begin
      wait_q1();
      instr_in = sasb_pkg::OPC_POWER_DOWN;
      repeat (3) cyc();
      check("sleep flags", 13'h0005, {10'h000, watchdog_expiry_flag_out,
            low_power_entry_flag_out, watchdog_clear_out});
      cyc();
      check("asleep", 13'h0000, {11'h000, osc_run_out, watchdog_clear_out});
      instr_in = {sasb_pkg::OPC_SUB_BORROW, 10'h3ff};
      repeat (4) cyc();
      instr_in = 16'h0000;
      watchdog_wake_in = ~k[0];
      wake_event_in = k[0];
      for (int n = 0; n < 10 && osc_run_out !== 1'b1; n++)
        cyc();
      if (osc_run_out !== 1'b1)
      begin
        check("wake", 13'h0001, 13'h0000);
        end_of_test();
      end
      watchdog_wake_in = 1'b0;
      wake_event_in = 1'b0;
      check("expiry after wake", {11'h000, k[0], 1'b0}, {11'h000, watchdog_expiry_flag_out,
            low_power_entry_flag_out});
    end
    repeat (4) cyc();
    end_of_test();
  end
endmodule
`default_nettype wire
